/* common/scr_pkg.sv */
package scr_pkg;

    // Register offsets on the internal register port
    localparam logic [7:0] SCR_MODE_ADDR = 8'h14;
    localparam logic [7:0] SCR_CFG_ADDR = 8'h15;
    localparam logic [7:0] SCR_KEEP_ADDR = 8'h18;

    // Configuration register values after reset, by strap level
    localparam logic [7:0] SCR_CFG_RST_GND = 8'h00;
    localparam logic [7:0] SCR_CFG_RST_VDD = 8'h03;
    localparam logic [2:0] SCR_KEEP_RST = 3'h0;

    // Operating mode codes
    localparam logic [1:0] SCR_MODE_STANDBY = 2'h0;
    localparam logic [1:0] SCR_MODE_WAKE = 2'h1;
    localparam logic [1:0] SCR_MODE_SLEEP = 2'h2;
    localparam logic [1:0] SCR_MODE_EXTERNAL_TRIGGER_MODE = 2'h3;

    // Timing
    localparam int unsigned SCR_CLK_MHZ = 100;
    localparam int unsigned SCR_START_DLY_MIN_US = 300;
    localparam int unsigned SCR_START_DLY_MAX_US = 500;
    localparam int unsigned SCR_START_DLY_CYC = SCR_START_DLY_MIN_US * SCR_CLK_MHZ;
    localparam int unsigned SCR_BOOT_TIME_US = 1000;
    localparam int unsigned SCR_BOOT_CYC = SCR_BOOT_TIME_US * SCR_CLK_MHZ;
    localparam int unsigned SCR_RST_PULSE_CYC = 4;
    localparam int unsigned SCR_INIT_CYC = 4;
    localparam int unsigned SCR_IRQ_PULSE_CYC = 8;
    localparam int unsigned SCR_CNT_W = 17;
    localparam int unsigned SCR_IRQ_W = 4;

    typedef struct packed {
        logic trig;
        logic [1:0] selftest_axis_select;
        logic selftest_polarity;
        logic spi_mode;
        logic [1:0] full_scale_range;
        logic active;
    } scr_cfg_t;

    typedef struct packed {
        logic boot_disable;
        logic irq_driver_type;
        logic irq_polarity;
    } scr_keep_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scr_req_t;

    typedef enum logic [2:0] {
        SCR_INIT,
        SCR_IDLE,
        SCR_WAIT_END,
        SCR_DELAY,
        SCR_RESET,
        SCR_BOOT
    } scr_state_t;

endpackage

/* logic/scr_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module scr_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic ref_clk_i,  // Clock
    input wire logic nrst_i,     // Async reset, active low
    input wire logic d_i,        // Asynchronous input
    output logic q_o             // Filtered level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_o <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

/* logic/scr_soft_reset.sv */
// Behaviour
// - Config register at 15h: trigger, self-test axis, polarity, SPI mode, range, active.
// - Config resets to 00h with strap grounded, 03h with strap at supply.
// - Writing one to the trigger bit requests soft reset; zero means none pending.
// - Soft reset request accepted in every operating mode.
// - Soft reset reloads defaults but keeps irq polarity, driver type, boot disable unless hibernate is enabled.
// - Soft reset also reinitialises the serial interface logic.
// - Reset waits for I2C stop or SPI chip-select release.
// - Trigger bit always reads back as zero.
// - Reset begins 300 to 500 us after the trigger is written; here START_DLY_CYC (300 us) after the I2C stop or chip-select release.
// - Boot completion is signalled as a pulse on the interrupt output.
// - After reset, standby with strap grounded; wake with strap high and motion detect.
`timescale 1ns/1ps
`default_nettype none
module scr_soft_reset
    import scr_pkg::*;
#(
    parameter int unsigned START_DLY_CYC = SCR_START_DLY_CYC,
    parameter int unsigned BOOT_CYC = SCR_BOOT_CYC
) (
    input wire logic ref_clk_i,                 // 100 MHz clock
    input wire logic nrst_i,                    // Power-on reset, active low
    input wire logic boot_mode_strap_i,         // Strap pin, 1 = supply
    input wire logic motion_detect_select_i,    // Motion detect selected
    input wire logic hibernate_i,               // Hibernate enabled
    input wire scr_req_t bus_req_i,             // Register access from serial logic
    input wire logic i2c_stop_i,                // I2C stop seen, one-cycle pulse
    input wire logic spi_cs_n_i,                // SPI chip select pin, active low
    output logic bus_ready_o,                   // Register port accepts access
    output logic [7:0] reg_rdata_o,             // Read data
    output scr_cfg_t cfg_o,                     // Config fields
    output scr_keep_t keep_o,                   // Bits kept over soft reset
    output logic [1:0] operating_mode_status_o, // Current mode
    output logic func_rst_o,                    // Functional block reset
    output logic serial_rst_o,                  // Serial interface reset
    output logic reset_pending_o,               // Soft reset requested
    output logic interrupt_output_o,            // Interrupt pin level
    output logic interrupt_output_oe_o          // Interrupt pin drive enable
);
    scr_state_t state_q;
    scr_state_t state_d;
    logic [SCR_CNT_W-1:0] cnt_q;
    logic [SCR_CNT_W-1:0] cnt_d;
    logic [SCR_IRQ_W-1:0] irq_cnt_q;
    logic [SCR_IRQ_W-1:0] irq_cnt_d;
    scr_cfg_t cfg_q;
    scr_cfg_t cfg_d;
    scr_keep_t keep_q;
    scr_keep_t keep_d;
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic [7:0] rdata_d;
    logic int_lvl_d;
    logic strap_s;
    logic cs_n_s;
    logic cs_n_prev_q;

    function automatic logic [SCR_CNT_W-1:0] cyc_load(input int unsigned n);
        cyc_load = (n > 0) ? SCR_CNT_W'(n - 1) : '0;
    endfunction

    function automatic logic [SCR_CNT_W-1:0] cnt_dec(input logic [SCR_CNT_W-1:0] c);
        cnt_dec = (c != '0) ? c - SCR_CNT_W'(1) : '0;
    endfunction

    scr_sync3 #(
        .RST_VAL(1'b0)
    ) u_strap_sync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .d_i(boot_mode_strap_i),
        .q_o(strap_s)
    );

    scr_sync3 #(
        .RST_VAL(1'b1)
    ) u_cs_sync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .d_i(spi_cs_n_i),
        .q_o(cs_n_s)
    );

    // Access is refused from the start of the reset until boot has finished
    wire busy = (state_q == SCR_INIT) || (state_q == SCR_RESET) || (state_q == SCR_BOOT);
    wire acc_ok = !busy;
    wire cnt_zero = (cnt_q == '0);
    wire cfg_hit = (bus_req_i.addr == SCR_CFG_ADDR);
    wire keep_hit = (bus_req_i.addr == SCR_KEEP_ADDR);
    wire mode_hit = (bus_req_i.addr == SCR_MODE_ADDR);
    wire cfg_wr = bus_req_i.wr && acc_ok && cfg_hit;
    wire keep_wr = bus_req_i.wr && acc_ok && keep_hit;
    wire rd_ok = bus_req_i.rd && acc_ok;
    wire scr_cfg_t wcfg = scr_cfg_t'(bus_req_i.wdata);
    // No mode term: the request is taken in standby, wake, sleep and trigger mode
    wire trig_req = cfg_wr && wcfg.trig && (state_q == SCR_IDLE);
    wire cs_rise = cs_n_s && !cs_n_prev_q;
    wire txn_end = i2c_stop_i || cs_rise;
    wire load_dflt = (state_q == SCR_RESET) && cnt_zero;
    wire boot_end = (state_q == SCR_BOOT) && cnt_zero;
    wire scr_cfg_t cfg_dflt = scr_cfg_t'(strap_s ? SCR_CFG_RST_VDD : SCR_CFG_RST_GND);
    wire [1:0] mode_dflt = (strap_s && motion_detect_select_i) ? SCR_MODE_WAKE : SCR_MODE_STANDBY;
    wire irq_act = (irq_cnt_d != '0);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_dec(cnt_q);
        case (state_q)
            SCR_INIT: begin
                if (cnt_zero) begin
                    state_d = SCR_RESET;
                    cnt_d = cyc_load(SCR_RST_PULSE_CYC);
                end
            end
            SCR_IDLE: begin
                if (trig_req) begin
                    state_d = SCR_WAIT_END;
                end
            end
            SCR_WAIT_END: begin
                if (txn_end) begin
                    state_d = SCR_DELAY;
                    cnt_d = cyc_load(START_DLY_CYC);
                end
            end
            SCR_DELAY: begin
                if (cnt_zero) begin
                    state_d = SCR_RESET;
                    cnt_d = cyc_load(SCR_RST_PULSE_CYC);
                end
            end
            SCR_RESET: begin
                if (cnt_zero) begin
                    state_d = SCR_BOOT;
                    cnt_d = cyc_load(BOOT_CYC);
                end
            end
            SCR_BOOT: begin
                if (cnt_zero) begin
                    state_d = SCR_IDLE;
                end
            end
            default: begin
                state_d = SCR_INIT;
                cnt_d = cyc_load(SCR_INIT_CYC);
            end
        endcase
    end

    always_comb begin
        cfg_d = cfg_q;
        keep_d = keep_q;
        mode_d = mode_q;
        if (load_dflt) begin
            cfg_d = cfg_dflt;
            mode_d = mode_dflt;
            if (hibernate_i) begin
                keep_d = scr_keep_t'(SCR_KEEP_RST);
            end
        end else begin
            if (cfg_wr) begin
                cfg_d = wcfg;
                cfg_d.trig = 1'b0;
                if (wcfg.active && (mode_q == SCR_MODE_STANDBY)) begin
                    mode_d = SCR_MODE_WAKE;
                end else if (!wcfg.active) begin
                    mode_d = SCR_MODE_STANDBY;
                end
            end
            if (keep_wr) begin
                keep_d = scr_keep_t'(bus_req_i.wdata[2:0]);
            end
        end
    end

    always_comb begin
        rdata_d = reg_rdata_o;
        if (rd_ok) begin
            if (cfg_hit) begin
                rdata_d = {1'b0, cfg_q[6:0]};
            end else if (keep_hit) begin
                rdata_d = {5'h00, keep_q};
            end else if (mode_hit) begin
                rdata_d = {6'h00, mode_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_comb begin
        irq_cnt_d = (irq_cnt_q != '0) ? irq_cnt_q - SCR_IRQ_W'(1) : '0;
        if (boot_end) begin
            irq_cnt_d = SCR_IRQ_W'(SCR_IRQ_PULSE_CYC);
        end
    end

    // Active level follows the kept polarity; open drain only pulls low
    assign int_lvl_d = irq_act ? keep_d.irq_polarity : !keep_d.irq_polarity;
    assign bus_ready_o = acc_ok;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= SCR_INIT;
            cnt_q <= SCR_CNT_W'(SCR_INIT_CYC - 1);
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_q <= scr_cfg_t'(SCR_CFG_RST_GND);
            keep_q <= scr_keep_t'(SCR_KEEP_RST);
            mode_q <= SCR_MODE_STANDBY;
            reg_rdata_o <= 8'h00;
            cs_n_prev_q <= 1'b1;
        end else begin
            cfg_q <= cfg_d;
            keep_q <= keep_d;
            mode_q <= mode_d;
            reg_rdata_o <= rdata_d;
            cs_n_prev_q <= cs_n_s;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            func_rst_o <= 1'b1;
            serial_rst_o <= 1'b1;
            reset_pending_o <= 1'b0;
        end else begin
            func_rst_o <= (state_d == SCR_RESET) || (state_d == SCR_INIT);
            serial_rst_o <= (state_d == SCR_RESET) || (state_d == SCR_INIT);
            reset_pending_o <= (state_d == SCR_WAIT_END) || (state_d == SCR_DELAY);
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_cnt_q <= '0;
            interrupt_output_o <= 1'b1;
            interrupt_output_oe_o <= 1'b1;
        end else begin
            irq_cnt_q <= irq_cnt_d;
            interrupt_output_o <= int_lvl_d;
            interrupt_output_oe_o <= !keep_d.irq_driver_type || !int_lvl_d;
        end
    end

    assign cfg_o = cfg_q;
    assign keep_o = keep_q;
    assign operating_mode_status_o = mode_q;

endmodule
`default_nettype wire

/* verification/scr_soft_reset_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module scr_soft_reset_sva
    import scr_pkg::*;
#(
    parameter int unsigned START_DLY_CYC = SCR_START_DLY_CYC,
    parameter int unsigned BOOT_CYC = SCR_BOOT_CYC
) (
    input wire logic ref_clk_i, // Clock
    input wire logic nrst_i, // Reset, active low
    input wire logic boot_mode_strap_i, // Strap
    input wire logic motion_detect_select_i, // Motion detect
    input wire logic hibernate_i, // Hibernate
    input wire scr_req_t bus_req_i, // Register access
    input wire logic i2c_stop_i, // Stop pulse
    input wire logic spi_cs_n_i, // Chip select
    input wire logic bus_ready_o, // Port ready
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire scr_cfg_t cfg_o, // Config
    input wire scr_keep_t keep_o, // Kept bits
    input wire logic [1:0] operating_mode_status_o, // Mode
    input wire logic func_rst_o, // Block reset
    input wire logic serial_rst_o, // Serial reset
    input wire logic reset_pending_o, // Pending
    input wire logic interrupt_output_o, // Irq level
    input wire logic interrupt_output_oe_o // Irq enable
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence rst_phase_s;
        func_rst_o [*4] ##1 !func_rst_o;
    endsequence
    sequence boot_quiet_s;
        !bus_ready_o [*8];
    endsequence
    wire cfg_wr = bus_ready_o && bus_req_i.wr && bus_req_i.addr == SCR_CFG_ADDR;
    trig_reads_zero_a: assert property (cfg_o.trig == 1'b0) else $error("trigger bit set");
    serial_reset_pair_a: assert property (serial_rst_o == func_rst_o) else $error("serial reset apart");
    reset_phase_len_a: assert property ($rose(func_rst_o) |-> rst_phase_s) else $error("reset width");
    busy_refuse_a: assert property (func_rst_o |-> !bus_ready_o) else $error("ready in reset");
    boot_quiet_a: assert property ($fell(func_rst_o) |-> boot_quiet_s) else $error("ready during boot");
    wire [7:0] cfg_exp = boot_mode_strap_i ? SCR_CFG_RST_VDD : SCR_CFG_RST_GND;
    wire [1:0] mode_exp = (boot_mode_strap_i && motion_detect_select_i) ? SCR_MODE_WAKE : SCR_MODE_STANDBY;
    defaults_load_a: assert property ($fell(func_rst_o) |-> cfg_o == cfg_exp
        && operating_mode_status_o == mode_exp) else $error("bad defaults");
    start_delay_a: assert property ($rose(reset_pending_o) |-> !func_rst_o [*8]) else $error("early start");
    trig_pending_a: assert property (cfg_wr && bus_req_i.wdata[7] && !reset_pending_o |=> reset_pending_o)
        else $error("no pending");
    cfg_write_a: assert property (cfg_wr |=> cfg_o[6:0] == $past(bus_req_i.wdata[6:0])) else $error("cfg write");
    boot_pulse_a: assert property ($rose(bus_ready_o) |-> ##[0:1] interrupt_output_o == keep_o.irq_polarity)
        else $error("no boot pulse");
    sequence irq_pulse_s;
        (interrupt_output_o == keep_o.irq_polarity) [*8] ##1 (interrupt_output_o != keep_o.irq_polarity);
    endsequence
    wire cfg_rd = bus_ready_o && bus_req_i.rd && bus_req_i.addr == SCR_CFG_ADDR;
    irq_pulse_len_a: assert property ($rose(bus_ready_o) |-> irq_pulse_s) else $error("boot pulse width");
    irq_drive_a: assert property (interrupt_output_oe_o == (!keep_o.irq_driver_type || !interrupt_output_o))
        else $error("irq drive enable");
    cfg_rd_zero_a: assert property (cfg_rd |=> !reg_rdata_o[7]) else $error("trigger read as one");
    pend_to_reset_a: assert property ($fell(reset_pending_o) |-> $rose(func_rst_o)) else $error("pending lost");
endmodule
bind scr_soft_reset scr_soft_reset_sva #(.START_DLY_CYC(START_DLY_CYC), .BOOT_CYC(BOOT_CYC)) scr_soft_reset_sva_inst (.*);
`default_nettype wire

/* verification/scr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scr_host_model
    import scr_pkg::*;
(
    input wire logic ref_clk_i, // Clock
    output scr_req_t bus_req_o, // Register access
    output logic i2c_stop_o, // Stop pulse
    output logic spi_cs_n_o // Chip select, active low
);
    initial begin
        bus_req_o = '0;
        i2c_stop_o = 1'b0;
        spi_cs_n_o = 1'b1;
    end
    // One-cycle strobe; bit 7 of a config write asks for soft reset
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge ref_clk_i);
        bus_req_o <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(posedge ref_clk_i);
        bus_req_o <= '0;
    endtask
    task automatic stop();
        @(posedge ref_clk_i);
        i2c_stop_o <= 1'b1;
        @(posedge ref_clk_i);
        i2c_stop_o <= 1'b0;
    endtask
    task automatic select(input logic on);
        @(posedge ref_clk_i);
        spi_cs_n_o <= !on;
    endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scr_pkg::*;
    localparam int unsigned DLY = 20;
    localparam int unsigned BOOT = 30;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic boot_mode_strap_i = 1'b0;
    logic motion_detect_select_i = 1'b0;
    logic hibernate_i = 1'b0;
    scr_req_t bus_req_i;
    logic i2c_stop_i, spi_cs_n_i, bus_ready_o, func_rst_o, serial_rst_o, reset_pending_o;
    logic interrupt_output_o, interrupt_output_oe_o;
    logic [7:0] reg_rdata_o;
    logic [1:0] operating_mode_status_o;
    scr_cfg_t cfg_o;
    scr_keep_t keep_o;
    int fails = 0;
    int n_compared = 0;
    int n;
    always #5 ref_clk_i = ~ref_clk_i;
    scr_soft_reset #(.START_DLY_CYC(DLY), .BOOT_CYC(BOOT)) scr_soft_reset_inst (.*);
    scr_host_model scr_host_model_inst (.ref_clk_i(ref_clk_i), .bus_req_o(bus_req_i), .i2c_stop_o(i2c_stop_i),
        .spi_cs_n_o(spi_cs_n_i));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        scr_host_model_inst.access(1'b1, addr, data);
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        scr_host_model_inst.access(1'b0, addr, 8'h00);
        #1 chk(reg_rdata_o, exp);
    endtask
    // Host resumes on the boot pulse instead of timing the boot
    task automatic wait_boot();
        n = 0;
        while (!(interrupt_output_o === keep_o.irq_polarity && bus_ready_o === 1'b1) && n < 500) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        chk({7'h00, n < 500}, 8'h01);
    endtask
    task automatic por();
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        wait_boot();
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        tally_and_finish();
    end
    initial begin
        por();
        rd(SCR_CFG_ADDR, SCR_CFG_RST_GND);
        rd(SCR_MODE_ADDR, {6'h00, SCR_MODE_STANDBY});
        wr(SCR_CFG_ADDR, 8'h7E);
        rd(SCR_CFG_ADDR, 8'h7E);
        wr(SCR_KEEP_ADDR, 8'h07);
        wr(SCR_CFG_ADDR, 8'hFF);
        rd(SCR_CFG_ADDR, 8'h7F);
        chk({7'h00, reset_pending_o}, 8'h01);
        repeat (40) @(posedge ref_clk_i);
        #1 chk({7'h00, func_rst_o}, 8'h00);
        scr_host_model_inst.stop();
        n = 0;
        while (func_rst_o !== 1'b1 && n < 100) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        chk({7'h00, n >= DLY && n <= DLY * 5 / 3}, 8'h01);
        wr(SCR_CFG_ADDR, 8'h06);
        wait_boot();
        rd(SCR_CFG_ADDR, SCR_CFG_RST_GND);
        rd(SCR_KEEP_ADDR, 8'h07);
        boot_mode_strap_i <= 1'b1;
        motion_detect_select_i <= 1'b1;
        hibernate_i <= 1'b1;
        por();
        rd(SCR_CFG_ADDR, SCR_CFG_RST_VDD);
        rd(SCR_MODE_ADDR, {6'h00, SCR_MODE_WAKE});
        wr(SCR_KEEP_ADDR, 8'h06);
        scr_host_model_inst.select(1'b1);
        wr(SCR_CFG_ADDR, 8'h80);
        // Open drain, active low, idle: pin released high
        #1 chk({6'h00, interrupt_output_o, interrupt_output_oe_o}, 8'h02);
        scr_host_model_inst.select(1'b0);
        repeat (4) @(posedge ref_clk_i);
        wait_boot();
        rd(SCR_KEEP_ADDR, 8'h00);
        rd(SCR_MODE_ADDR, {6'h00, SCR_MODE_WAKE});
        rd(SCR_CFG_ADDR, SCR_CFG_RST_VDD);
        tally_and_finish();
    end
endmodule
`default_nettype wire
